// ---- verilog/adccfg_reg_bank.sv ----
/*
  Configuration register bank of a multi-channel pipelined converter with
  its three-wire serial slave port (chip select, serial clock, data in/out).
  Assumes the serial clock runs at no more than one eighth of clk_sys and
  that the surrounding pad logic resolves the data pin from sdio_oe_n.
*/
`timescale 1ns/10ps

// What this block does
// - Load defaults 2^20 clocks after power-on reset.
// - Hardware reset pin restores every default.
// - Decode registers only in sparse 0x00-0x15D.
// - All read/write except top four read-only.
// - Each register is one 8-bit volatile byte.
// - Serial command with address reads or writes registers.
// - Register 0x00 mirrors four controls, resets 0x24.
// - Register 0x01 divider, channel count, resets 0x0F.
// - Register 0x04 output timing in b7, 0x9F.
// - Register 0x07 polarity, autocal, randomizer, 0x62.
// - Register 0x59 refdiv and loop enables, 0x41.
// - Register 0x5F loop output, bias enables, 0xF1.
// - Resistor register five-bit code, b7 unimplemented.
// - Capacitor registers five-bit code, reset 0x27 except 0x5B at 0x20.
// - Register 0x62 format, mode, pattern, 0x10.
// - Register 0x63 load and drive current, 0x01.
// - Register 0x65 six invert bits, 0x00.
// - Register 0x66 offset low byte, reset zero.
// - Unimplemented bits always read zero.
module adccfg_reg_bank import adccfg_pkg::*; #(
  parameter int unsigned POR_CYCLES = ADCCFG_POR_CYCLES,
  // Factory contents of the read-only registers; values are arbitrary.
  parameter logic [7:0] FACTORY_VAL [ADCCFG_NRO] = '{8'h00, 8'h00, 8'h00, 8'h00}
) (
  // Clock and power-on reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Hardware reset pin and device address straps.
  input wire logic hw_reset_n,
  input wire logic [1:0] dev_adr,
  // Serial port pins.
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  // Load status.
  output logic cfg_ready,
  // Mode controls.
  output logic power_down,
  output logic lsb_first,
  output logic soft_reset_n,
  output logic standby,
  output logic independent_divider_enable,
  output logic [2:0] channel_count_select,
  output logic [3:0] output_word_rate,
  output logic [3:0] output_clock_rate,
  output logic serial_out_timing_select,
  output logic word_clock_polarity,
  output logic autocal_delay_enable,
  output logic randomizer_enable,
  // Loop controls.
  output logic loop_refdiv_enable,
  output logic loop_enable,
  output logic loop_out_enable,
  output logic loop_bias_enable,
  output logic [4:0] loop_filter_res_code,
  output logic [4:0] loop_filter_cap_a,
  output logic [4:0] loop_filter_cap_b,
  output logic [4:0] loop_filter_cap_c,
  // Output format and drive.
  output logic data_format,
  output logic [1:0] output_mode,
  output logic [2:0] test_pattern_select,
  output logic diff_load_select,
  output logic [2:0] diff_drive_current,
  output logic [5:0] diff_pair_invert,
  output logic [7:0] global_offset_value
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR = 3'b001,
    ST_WR = 3'b010,
    ST_RD = 3'b011,
    ST_SKIP = 3'b100
  } adccfg_state_t;

  adccfg_init_if init_bus();

  logic [ADCCFG_NPIN-1:0] pin_s;
  logic cs_n_s, sclk_s, sdi_s, hw_rst_n_s;
  logic [1:0] adr_s;
  logic sclk_d_reg;
  adccfg_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [1:0] byte_cnt_reg;
  logic [1:0] len_reg;
  logic [15:0] hdr_reg;
  logic [7:0] sh_reg;
  logic [ADCCFG_AW-1:0] addr_reg;
  logic wr_stb_reg;
  logic [ADCCFG_AW-1:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic sdo_reg;
  logic oe_n_reg;

  // Power-on load timer.
  adccfg_por_timer #(.CYCLES(POR_CYCLES)) u_timer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .init(init_bus.timer)
  );

  // All pins cross into clk_sys through two flops before anything looks.
  adccfg_sync #(.W(ADCCFG_NPIN), .IDLE(ADCCFG_PIN_IDLE)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d({dev_adr, hw_reset_n, sdio_in, spi_sclk, spi_cs_n}),
    .q(pin_s)
  );
  assign {adr_s, hw_rst_n_s, sdi_s, sclk_s, cs_n_s} = pin_s;

  // Edge detection on the synchronised serial clock.
  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;
  wire bank_ready = init_bus.ready & hw_rst_n_s;
  wire load_all = init_bus.load_defaults | ~hw_rst_n_s;

  // Incoming bit assembled in the order chosen by the bit-order control.
  wire [15:0] hdr_shift = lsb_first ? {sdi_s, hdr_reg[15:1]} : {hdr_reg[14:0], sdi_s};
  wire [7:0] byte_shift = lsb_first ? {sdi_s, sh_reg[7:1]} : {sh_reg[6:0], sdi_s};
  wire hdr_is_read = hdr_shift[ADCCFG_HDR_RW];
  wire [1:0] hdr_len = hdr_shift[ADCCFG_HDR_LEN_HI:ADCCFG_HDR_LEN_LO];
  wire [2:0] hdr_dev = hdr_shift[ADCCFG_HDR_DEV_HI:ADCCFG_HDR_DEV_LO];
  wire dev_match = (hdr_dev == {ADCCFG_DEV_A2, adr_s});
  wire byte_end = (bit_cnt_reg == ADCCFG_BYTE_LAST);
  wire last_byte = (len_reg != ADCCFG_LEN_STREAM) && (byte_cnt_reg == len_reg);

  // Read path: sparse decode, masked data, read-only block on top.
  logic [ADCCFG_NREG-1:0] rd_hit;
  logic [ADCCFG_NREG-1:0] wr_hit;
  logic [7:0] cfg_q [ADCCFG_NREG];
  logic [7:0] rd_acc [ADCCFG_NREG+1];
  logic [ADCCFG_NREG*8-1:0] cfg_flat;
  logic [ADCCFG_NREG*8-1:0] rst_flat;
  wire [ADCCFG_AW-1:0] ro_off = addr_reg - ADCCFG_RO_BASE;
  wire ro_hit = (addr_reg >= ADCCFG_RO_BASE) && (addr_reg <= ADCCFG_ADDR_MAX);
  wire [7:0] rd_data = ro_hit ? FACTORY_VAL[ro_off[ADCCFG_RO_IW-1:0]] : rd_acc[ADCCFG_NREG];
  wire [7:0] rd_first = lsb_first ? {7'h00, rd_data[0]} : {7'h00, rd_data[7]};
  wire [7:0] sh_out = lsb_first ? {1'b0, sh_reg[7:1]} : {sh_reg[6:0], 1'b0};
  wire [7:0] mode_wdata = {wr_data_reg[7:4], wr_data_reg[4], wr_data_reg[5],
                           wr_data_reg[6], wr_data_reg[7]};
  wire wr_ok = |wr_hit;

  assign rd_acc[0] = 8'h00;

  // One storage byte per implemented address, each with its own decode.
  generate
    for (genvar i = 0; i < ADCCFG_NREG; i++) begin : g_reg
      logic [7:0] cfg_reg;
      wire [7:0] wr_val = (i == IX_MODE) ? mode_wdata : wr_data_reg;
      assign rd_hit[i] = (addr_reg == ADCCFG_ADDR[i]);
      assign wr_hit[i] = wr_stb_reg && (wr_addr_reg == ADCCFG_ADDR[i]);
      assign rd_acc[i+1] = rd_acc[i] | (rd_hit[i] ? cfg_reg : 8'h00);
      assign cfg_q[i] = cfg_reg;
      assign cfg_flat[i*8 +: 8] = cfg_reg;
      assign rst_flat[i*8 +: 8] = ADCCFG_RST[i];
      // Default load outranks a write landing in the same cycle.
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          cfg_reg <= ADCCFG_RST[i];
        end else if (load_all) begin
          cfg_reg <= ADCCFG_RST[i];
        end else if (wr_hit[i]) begin
          cfg_reg <= wr_val & ADCCFG_IMPL[i];
        end
      end
    end
  endgenerate

  // Serial clock history for the edge detectors.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
    end
  end

  // Serial frame sequencer: header, then write or read bytes, streaming
  // through the address counter. A frame for another device address, or
  // one that runs past its length, is ignored until chip select rises.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= ADCCFG_CNT_ZERO;
      byte_cnt_reg <= 2'h0;
      len_reg <= 2'h0;
      hdr_reg <= 16'h0000;
      sh_reg <= 8'h00;
      addr_reg <= '0;
      wr_stb_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= 8'h00;
      sdo_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      wr_stb_reg <= 1'b0;
      if (cs_n_s || !bank_ready) begin
        state_reg <= ST_IDLE;
        oe_n_reg <= 1'b1;
      end else begin
        unique case (state_reg)
          ST_IDLE: begin
            state_reg <= ST_HDR;
            bit_cnt_reg <= ADCCFG_CNT_ZERO;
            byte_cnt_reg <= 2'h0;
          end
          ST_HDR: begin
            if (sclk_rise) begin
              hdr_reg <= hdr_shift;
              bit_cnt_reg <= bit_cnt_reg + ADCCFG_CNT_ONE;
              if (bit_cnt_reg == ADCCFG_HDR_LAST) begin
                addr_reg <= hdr_shift[ADCCFG_AW-1:0];
                len_reg <= hdr_len;
                bit_cnt_reg <= ADCCFG_CNT_ZERO;
                if (!dev_match) begin
                  state_reg <= ST_SKIP;
                end else if (hdr_is_read) begin
                  state_reg <= ST_RD;
                end else begin
                  state_reg <= ST_WR;
                end
              end
            end
          end
          ST_WR: begin
            if (sclk_rise) begin
              sh_reg <= byte_shift;
              bit_cnt_reg <= bit_cnt_reg + ADCCFG_CNT_ONE;
              if (byte_end) begin
                wr_stb_reg <= 1'b1;
                wr_addr_reg <= addr_reg;
                wr_data_reg <= byte_shift;
                addr_reg <= addr_reg + 10'h001;
                byte_cnt_reg <= byte_cnt_reg + 2'h1;
                bit_cnt_reg <= ADCCFG_CNT_ZERO;
                if (last_byte) begin
                  state_reg <= ST_SKIP;
                end
              end
            end
          end
          ST_RD: begin
            // Data leaves on falling edges; the pin is driven from the
            // first falling edge after the header.
            if (sclk_fall) begin
              oe_n_reg <= 1'b0;
              if (bit_cnt_reg == ADCCFG_CNT_ZERO) begin
                sh_reg <= rd_data;
                sdo_reg <= rd_first[0];
              end else begin
                sh_reg <= sh_out;
                sdo_reg <= lsb_first ? sh_out[0] : sh_out[7];
              end
            end
            if (sclk_rise) begin
              bit_cnt_reg <= bit_cnt_reg + ADCCFG_CNT_ONE;
              if (byte_end) begin
                addr_reg <= addr_reg + 10'h001;
                byte_cnt_reg <= byte_cnt_reg + 2'h1;
                bit_cnt_reg <= ADCCFG_CNT_ZERO;
                if (last_byte) begin
                  state_reg <= ST_SKIP;
                end
              end
            end
          end
          ST_SKIP: begin
            // Release the pin on the next falling edge so the final bit
            // keeps its full hold time.
            if (sclk_fall) begin
              oe_n_reg <= 1'b1;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Port pins and load status.
  assign sdio_out = sdo_reg;
  assign sdio_oe_n = oe_n_reg;
  assign cfg_ready = init_bus.ready;

  // Mode register: upper half is authoritative, lower half mirrors it.
  assign power_down = cfg_q[IX_MODE][7];
  assign lsb_first = cfg_q[IX_MODE][6];
  assign soft_reset_n = cfg_q[IX_MODE][5];
  assign standby = cfg_q[IX_MODE][4];
  assign independent_divider_enable = cfg_q[IX_NCH][7];
  assign channel_count_select = cfg_q[IX_NCH][5:3];
  assign output_word_rate = cfg_q[IX_RATE][7:4];
  assign output_clock_rate = cfg_q[IX_RATE][3:0];
  assign serial_out_timing_select = cfg_q[IX_SDO][7];
  assign word_clock_polarity = cfg_q[IX_RAND][7];
  assign autocal_delay_enable = cfg_q[IX_RAND][6];
  assign randomizer_enable = cfg_q[IX_RAND][0];

  // Loop setup fields.
  assign loop_refdiv_enable = cfg_q[IX_LEN1][4];
  assign loop_enable = cfg_q[IX_LEN1][1];
  assign loop_out_enable = cfg_q[IX_LEN2][3];
  assign loop_bias_enable = cfg_q[IX_LEN2][2];
  assign loop_filter_res_code = cfg_q[IX_RES][4:0];
  assign loop_filter_cap_a = cfg_q[IX_CAPA][4:0];
  assign loop_filter_cap_b = cfg_q[IX_CAPB][4:0];
  assign loop_filter_cap_c = cfg_q[IX_CAPC][4:0];

  // Output format and drive; the low two polarity bits steer nothing.
  assign data_format = cfg_q[IX_FMT][5];
  assign output_mode = cfg_q[IX_FMT][4:3];
  assign test_pattern_select = cfg_q[IX_FMT][2:0];
  assign diff_load_select = cfg_q[IX_DRV][3];
  assign diff_drive_current = cfg_q[IX_DRV][2:0];
  assign diff_pair_invert = cfg_q[IX_POL][7:2];
  assign global_offset_value = cfg_q[IX_OFS];

  // Checks on the bank's own behaviour.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence s_por_load;
    init_bus.load_defaults ##1 init_bus.ready;
  endsequence

  property p_por_defaults;
    s_por_load |-> (cfg_flat == rst_flat);
  endproperty
  a_por_defaults: assert property (p_por_defaults) else $error("defaults not loaded");

  property p_pin_defaults;
    !hw_rst_n_s |=> (cfg_flat == rst_flat) && (state_reg == ST_IDLE);
  endproperty
  a_pin_defaults: assert property (p_pin_defaults) else $error("pin reset missed");

  property p_unmapped_read;
    (rd_data != 8'h00) |-> (addr_reg <= ADCCFG_ADDR_MAX);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("read outside map");

  property p_ro_read;
    (addr_reg == ADCCFG_RO_BASE) |-> (rd_data == FACTORY_VAL[0]);
  endproperty
  a_ro_read: assert property (p_ro_read) else $error("read-only value wrong");

  property p_write_lands;
    (wr_stb_reg && wr_addr_reg == ADCCFG_ADDR[IX_OFS] && !load_all)
      |=> (global_offset_value == $past(wr_data_reg));
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write lost");

  sequence s_byte_in;
    (state_reg == ST_WR) && sclk_rise && byte_end && !cs_n_s && bank_ready;
  endsequence

  property p_write_strobe;
    s_byte_in |=> wr_stb_reg ##1 !wr_stb_reg;
  endproperty
  a_write_strobe: assert property (p_write_strobe) else $error("bad write strobe");

  property p_read_drive;
    (state_reg == ST_RD) && sclk_fall && !cs_n_s && bank_ready
      |=> !sdio_oe_n && (sdio_out == $past(rd_first[0])
                         || $past(bit_cnt_reg) != ADCCFG_CNT_ZERO);
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read bit wrong");

  property p_mirror;
    cfg_q[IX_MODE][3:0] == {cfg_q[IX_MODE][4], cfg_q[IX_MODE][5],
                           cfg_q[IX_MODE][6], cfg_q[IX_MODE][7]};
  endproperty
  a_mirror: assert property (p_mirror) else $error("mode mirror broken");

  property p_unimpl_zero;
    (addr_reg == ADCCFG_ADDR[IX_FMT]) || (addr_reg == ADCCFG_ADDR[IX_RES])
      |-> (rd_data[7] == 1'b0);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

  property p_no_stray_write;
    wr_stb_reg && !wr_ok && !load_all |=> $stable(cfg_flat);
  endproperty
  a_no_stray_write: assert property (p_no_stray_write) else $error("stray write");

endmodule

// ---- verilog/adccfg_pkg.sv ----
/*
  Shared constants of the converter configuration register bank: register
  map, reset values, implemented-bit masks, serial header layout and timing.
  Assumes nothing of its surroundings; the bank and the load timer import it whole.
*/
package adccfg_pkg;

  // Register map size, address width and the serial byte width.
  localparam int ADCCFG_NREG = 24;
  localparam int ADCCFG_AW = 10;
  localparam int ADCCFG_DW = 8;

  // Implemented register addresses, in the order of the storage entries.
  localparam logic [9:0] ADCCFG_ADDR [ADCCFG_NREG] = '{
    10'h000, 10'h001, 10'h002, 10'h004, 10'h007, 10'h01e, 10'h052, 10'h053,
    10'h054, 10'h055, 10'h056, 10'h057, 10'h058, 10'h059, 10'h05a, 10'h05b,
    10'h05c, 10'h05d, 10'h05f, 10'h062, 10'h063, 10'h064, 10'h065, 10'h066};

  // Default values loaded at power-up and by the hardware reset pin.
  localparam logic [7:0] ADCCFG_RST [ADCCFG_NREG] = '{
    8'h24, 8'h0f, 8'h00, 8'h9f, 8'h62, 8'h80, 8'h0a, 8'h45,
    8'h00, 8'h48, 8'h78, 8'h40, 8'h12, 8'h41, 8'h20, 8'h20,
    8'h27, 8'h27, 8'hf1, 8'h10, 8'h01, 8'h03, 8'h00, 8'h00};

  // Implemented bits; the rest store nothing and read as zero.
  localparam logic [7:0] ADCCFG_IMPL [ADCCFG_NREG] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h7f, 8'h7f,
    8'h7f, 8'h7f, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff};

  // Storage indexes of the registers whose fields leave the block.
  localparam int IX_MODE = 0;
  localparam int IX_NCH = 1;
  localparam int IX_RATE = 2;
  localparam int IX_SDO = 3;
  localparam int IX_RAND = 4;
  localparam int IX_LEN1 = 13;
  localparam int IX_RES = 14;
  localparam int IX_CAPC = 15;
  localparam int IX_CAPA = 16;
  localparam int IX_CAPB = 17;
  localparam int IX_LEN2 = 18;
  localparam int IX_FMT = 19;
  localparam int IX_DRV = 20;
  localparam int IX_POL = 22;
  localparam int IX_OFS = 23;

  // Read-only block at the top of the decoded space.
  localparam int ADCCFG_NRO = 4;
  localparam int ADCCFG_RO_IW = 2;
  localparam logic [9:0] ADCCFG_RO_BASE = 10'h15a;
  localparam logic [9:0] ADCCFG_ADDR_MAX = 10'h15d;

  // Instruction header: R/W, length, device address, start address.
  localparam int ADCCFG_HDR_RW = 15;
  localparam int ADCCFG_HDR_LEN_HI = 14;
  localparam int ADCCFG_HDR_LEN_LO = 13;
  localparam int ADCCFG_HDR_DEV_HI = 12;
  localparam int ADCCFG_HDR_DEV_LO = 10;
  localparam logic ADCCFG_DEV_A2 = 1'b0;
  localparam logic [1:0] ADCCFG_LEN_STREAM = 2'h3;
  localparam logic [3:0] ADCCFG_HDR_LAST = 4'hf;
  localparam logic [3:0] ADCCFG_BYTE_LAST = 4'h7;
  localparam logic [3:0] ADCCFG_CNT_ZERO = 4'h0;
  localparam logic [3:0] ADCCFG_CNT_ONE = 4'h1;

  // Pin synchroniser order {adr1, adr0, hw_reset_n, sdio, sclk, cs_n}.
  localparam int ADCCFG_NPIN = 6;
  localparam logic [5:0] ADCCFG_PIN_IDLE = 6'h09;

  // Power-on load delay in converter clock cycles.
  localparam int ADCCFG_POR_CYCLES = 1 << 20;

endpackage

// ---- verilog/adccfg_init_if.sv ----
/*
  Carrier between the power-on load timer and the register bank.
  Assumes both ends run on clk_sys.
*/
`timescale 1ns/10ps
interface adccfg_init_if;
  logic load_defaults;
  logic ready;
  modport timer (output load_defaults, output ready);
  modport bank (input load_defaults, input ready);
endinterface

// ---- verilog/adccfg_sync.sv ----
/*
  Two-stage synchroniser for a group of asynchronous pins.
  Assumes each pin is a slow level relative to clk_sys.
*/
`timescale 1ns/10ps
module adccfg_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] IDLE = '0
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Pins in, synchronised levels out.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // The first stage feeds the second stage only.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= IDLE;
      q <= IDLE;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ---- verilog/adccfg_por_timer.sv ----
/*
  Power-on load timer: counts converter clocks after reset release, then
  pulses a default load once and raises ready for the rest of the session.
  Assumes rstn is the power-on reset.
*/
`timescale 1ns/10ps
module adccfg_por_timer import adccfg_pkg::*; #(
  parameter int unsigned CYCLES = ADCCFG_POR_CYCLES
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Load pulse and ready level.
  adccfg_init_if.timer init
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] cnt_reg;
  logic load_reg;
  logic ready_reg;

  // Counting stops for good once ready is up.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
      load_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      load_reg <= 1'b0;
      if (!ready_reg) begin
        if (cnt_reg == LAST) begin
          load_reg <= 1'b1;
          ready_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + ONE;
        end
      end
    end
  end

  assign init.load_defaults = load_reg;
  assign init.ready = ready_reg;
endmodule

// ---- verification/adccfg_host.sv ----
/*
  Serial host model: drives chip select, serial clock and data, and samples
  the resolved data line during read bytes. Assumes the testbench resolves
  the line and that 6 clk_sys per serial phase suit the bank's synchroniser.
*/
`timescale 1ns/10ps
module adccfg_host (
  // Clock.
  input wire logic clk_sys,
  // Serial pins.
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic host_d,
  output logic host_oe,
  input wire logic sdio_line
);
  // Idle: deselected, clock parked low, data released.
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    host_d = 1'b0;
    host_oe = 1'b0;
  end

  // Frame bit order; the testbench keeps it equal to the bank's lsb_first.
  logic lsbf = 1'b0;

  // One frame, MSb or LSb first: header, then n bytes sent from wd or read into rd.
  // Data changes with the falling phase and is sampled just before the rise.
  task automatic xfer(input logic [15:0] hdr, input int n, input logic [7:0] wd [4],
                      output logic [7:0] rd [4]);
    int k;
    @(posedge clk_sys);
    spi_cs_n <= 1'b0;
    for (int b = 0; b < 16 + 8 * n; b++) begin
      @(posedge clk_sys);
      k = lsbf ? b % 8 : 7 - b % 8;
      spi_sclk <= 1'b0;
      host_oe <= (b < 16) || !hdr[15];
      host_d <= (b < 16) ? hdr[lsbf ? b : 15 - b] : wd[b / 8 - 2][k];
      repeat (6) @(posedge clk_sys);
      if (b >= 16) rd[b / 8 - 2][k] = sdio_line;
      spi_sclk <= 1'b1;
      repeat (5) @(posedge clk_sys);
    end
    spi_cs_n <= 1'b1;
    spi_sclk <= 1'b0;
    host_oe <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule

// ---- verification/adc_config_register_bank_tb.sv ----
/*
  Self-checking testbench of the configuration register bank.
  Assumes the host model above; a shadow copy of the map gives expectations.
*/
`timescale 1ns/10ps
module adc_config_register_bank_tb import adccfg_pkg::*; ;
  localparam logic [2:0] DEV = 3'b010;
  localparam logic [9:0] BAD [3] = '{10'h15a, 10'h003, 10'h15e};
  // User fields and unimplemented bits per entry; the host keeps factory bits as preset.
  localparam logic [7:0] FLD [ADCCFG_NREG] = '{
    8'hff, 8'hb8, 8'hff, 8'h80, 8'hc1, 8'hff, 8'hff, 8'h10, 8'hff, 8'hf3, 8'hff, 8'h0f,
    8'h1f, 8'h92, 8'h9f, 8'h9f, 8'h9f, 8'h9f, 8'h0c, 8'hbf, 8'h0f, 8'hf0, 8'hff, 8'hff};
  // Clock, resets, pins and observed controls.
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic hw_reset_n = 1'b1;
  logic tgl = 1'b0;
  logic spi_cs_n, spi_sclk, host_d, host_oe, sdio_out, sdio_oe_n, cfg_ready;
  logic power_down, lsb_first, soft_reset_n, standby, independent_divider_enable;
  logic serial_out_timing_select, word_clock_polarity, autocal_delay_enable;
  logic randomizer_enable, loop_refdiv_enable, loop_enable, loop_out_enable;
  logic loop_bias_enable, data_format, diff_load_select;
  logic [1:0] output_mode;
  logic [2:0] channel_count_select, test_pattern_select, diff_drive_current;
  logic [3:0] output_word_rate, output_clock_rate;
  logic [4:0] loop_filter_res_code, loop_filter_cap_a, loop_filter_cap_b, loop_filter_cap_c;
  logic [5:0] diff_pair_invert;
  logic [7:0] global_offset_value;
  logic [7:0] mdl [ADCCFG_NREG];
  logic [7:0] wd [4] = '{8'hff, 8'hff, 8'hff, 8'h00};
  logic [7:0] rb [4];
  int n_mismatch = 0;
  int num_checks = 0;

  // A released line shows a toggling level so no stale value can pass.
  wire logic sdio_line = !sdio_oe_n ? sdio_out : host_oe ? host_d : tgl;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) tgl <= ~tgl;

  adccfg_host adccfg_host_inst (.clk_sys, .spi_cs_n, .spi_sclk, .host_d, .host_oe, .sdio_line);
  adccfg_reg_bank #(.POR_CYCLES(16), .FACTORY_VAL('{8'h5c, 8'h00, 8'h00, 8'h00}))
    adccfg_reg_bank_inst (.*, .dev_adr(2'b10), .sdio_in(sdio_line));

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Release power-on reset and count edges until the load completes.
  task automatic boot(output int n);
    rstn <= 1'b1;
    n = 0;
    while (cfg_ready !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    repeat (4) @(posedge clk_sys);
    mdl = ADCCFG_RST;
  endtask

  task automatic wr(input int i, input logic [7:0] v);
    wd[0] = (v & FLD[i]) | (mdl[i] & ~FLD[i]);
    adccfg_host_inst.xfer({1'b0, 2'h0, DEV, ADCCFG_ADDR[i]}, 1, wd, rb);
    mdl[i] = wd[0] & ADCCFG_IMPL[i];
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    adccfg_host_inst.xfer({1'b1, 2'h0, DEV, a}, 1, wd, rb);
    chk("rdata", rb[0], e);
  endtask

  // Read every read/write register back, then compare the control outputs field by field.
  task automatic check_all();
    for (int i = 0; i < ADCCFG_NREG; i++) rd(ADCCFG_ADDR[i], mdl[i]);
    chk("mode", {power_down, lsb_first, soft_reset_n, standby, 4'h0}, mdl[0] & 8'hf0);
    chk("nch", {independent_divider_enable, 1'b0, channel_count_select, 3'h0},
        mdl[IX_NCH] & 8'hb8);
    chk("rate", {output_word_rate, output_clock_rate}, mdl[IX_RATE]);
    chk("sdo", {serial_out_timing_select, 7'h0}, mdl[IX_SDO] & 8'h80);
    chk("rand", {word_clock_polarity, autocal_delay_enable, 5'h0, randomizer_enable},
        mdl[IX_RAND] & 8'hc1);
    chk("len1", {3'h0, loop_refdiv_enable, 2'h0, loop_enable, 1'b0}, mdl[IX_LEN1] & 8'h12);
    chk("len2", {4'h0, loop_out_enable, loop_bias_enable, 2'h0}, mdl[IX_LEN2] & 8'h0c);
    chk("res", {3'h0, loop_filter_res_code}, mdl[IX_RES] & 8'h1f);
    chk("cap", {3'h0, loop_filter_cap_a}, mdl[IX_CAPA] & 8'h1f);
    chk("capb", {3'h0, loop_filter_cap_b}, mdl[IX_CAPB] & 8'h1f);
    chk("capc", {3'h0, loop_filter_cap_c}, mdl[IX_CAPC] & 8'h1f);
    chk("fmt", {2'h0, data_format, output_mode, test_pattern_select}, mdl[IX_FMT] & 8'h3f);
    chk("drv", {4'h0, diff_load_select, diff_drive_current}, mdl[IX_DRV] & 8'h0f);
    chk("pol", {diff_pair_invert, 2'h0}, mdl[IX_POL] & 8'hfc);
    chk("ofs", global_offset_value, mdl[IX_OFS]);
  endtask

  // The all-ones sweep sets every user field and unimplemented bit except in register 0x00, which gets 0x80; factory bits
  // keep their presets because the host must never change them.
  task automatic t_write();
    for (int i = 1; i < 21; i++) wr(i, 8'hff);
    wd[0] = 8'hf3;
    adccfg_host_inst.xfer({1'b0, 2'h2, DEV, 10'h064}, 3, wd, rb);
    for (int i = 21; i < 24; i++) mdl[i] = wd[i - 21];
    wr(0, 8'h80);
    mdl[0] = 8'h81;
    check_all();
    $display("test write done");
  endtask

  // Wrong device, read-only and undecoded addresses must change nothing.
  task automatic t_refuse();
    wd[0] = 8'h00;
    adccfg_host_inst.xfer({1'b0, 2'h0, 3'b000, 10'h066}, 1, wd, rb);
    wd[0] = 8'hff;
    for (int k = 0; k < 3; k++) adccfg_host_inst.xfer({1'b0, 2'h0, DEV, BAD[k]}, 1, wd, rb);
    rd(10'h15a, 8'h5c);
    rd(10'h003, 8'h00);
    rd(10'h15e, 8'h00);
    check_all();
    $display("test refuse done");
  endtask

  // Bit order flips once the mode write lands, so the host follows from the next frame.
  task automatic t_lsb();
    wr(0, 8'h40);
    mdl[0] = 8'h42;
    adccfg_host_inst.lsbf = 1'b1;
    wr(IX_OFS, 8'h35);
    check_all();
    wr(0, 8'h24);
    adccfg_host_inst.lsbf = 1'b0;
    rd(10'h000, 8'h24);
    $display("test lsb done");
  endtask

  task automatic t_resets();
    int n;
    @(posedge clk_sys);
    hw_reset_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    hw_reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    mdl = ADCCFG_RST;
    check_all();
    wr(IX_OFS, 8'h5a);
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("ready_low", {7'h0, cfg_ready}, 8'h00);
    boot(n);
    chk("por_wait", n[7:0], 8'h10);
    check_all();
    $display("test resets done");
  endtask

  initial begin
    #800000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    int n;
    repeat (20) @(posedge clk_sys);
    boot(n);
    check_all();
    $display("test defaults done");
    t_write();
    t_refuse();
    t_lsb();
    t_resets();
    stop_test();
  end
endmodule
